// *** inc/dtc_pkg.sv ***
// Constants and types shared by the dual timer/counter block
`default_nettype none

package dtc_pkg;

   // ********************************************************
   // Bus geometry
   // ********************************************************
   localparam int ADR_W = 10;
   localparam int IDX_W = 8;

   // ********************************************************
   // Register indices (byte address is four times the index)
   // ********************************************************
   localparam logic [IDX_W-1:0] IDX_CTRL = 8'h88;
   localparam logic [IDX_W-1:0] IDX_MODE = 8'h89;
   localparam logic [IDX_W-1:0] IDX_TL0 = 8'h8a;
   localparam logic [IDX_W-1:0] IDX_TL1 = 8'h8b;
   localparam logic [IDX_W-1:0] IDX_TH0 = 8'h8c;
   localparam logic [IDX_W-1:0] IDX_TH1 = 8'h8d;

   // ********************************************************
   // Field positions in timer_control
   // ********************************************************
   localparam int CTL_TF1 = 7;
   localparam int CTL_TR1 = 6;
   localparam int CTL_TF0 = 5;
   localparam int CTL_TR0 = 4;
   localparam int CTL_IE1 = 3;
   localparam int CTL_IT1 = 2;
   localparam int CTL_IE0 = 1;
   localparam int CTL_IT0 = 0;

   // ********************************************************
   // Field positions in timer_mode_select
   // ********************************************************
   localparam int MOD_TIMER1_PIN_GATING = 7;
   localparam int MOD_CT1 = 6;
   localparam int MOD_M1_HI = 5;
   localparam int MOD_M1_LO = 4;
   localparam int MOD_TIMER0_PIN_GATING = 3;
   localparam int MOD_CT0 = 2;
   localparam int MOD_M0_HI = 1;
   localparam int MOD_M0_LO = 0;

   // ********************************************************
   // Pin slots in the synchroniser
   // ********************************************************
   localparam int PIN_IRQ0 = 0;
   localparam int PIN_IRQ1 = 1;
   localparam int PIN_CNT0 = 2;
   localparam int PIN_CNT1 = 3;
   localparam int PIN_N = 4;

   // ********************************************************
   // Reset values and timing
   // ********************************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int CLK_NS = 10;
   localparam int PERIPH_NS = 60;
   localparam logic [2:0] PERIPH_CYC = 3'(PERIPH_NS / CLK_NS);

   typedef enum logic [1:0] {
      MODE_13BIT,
      MODE_16BIT,
      MODE_RELOAD,
      MODE_SPLIT
   } dtc_mode_t;

endpackage

`default_nettype wire

// *** inc/dtc_pin_if.sv ***
// Raw and filtered pin levels between top and synchroniser
`default_nettype none

interface dtc_pin_if;
   import dtc_pkg::*;
   logic [PIN_N-1:0] raw;
   logic [PIN_N-1:0] filt;
   logic [PIN_N-1:0] fall;
   modport sync_end (input raw, output filt, output fall);
   modport user_end (output raw, input filt, input fall);
endinterface

`default_nettype wire

// *** design/dtc_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`default_nettype none

module dtc_pin_sync
   import dtc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   dtc_pin_if.sync_end pin
);

   logic [PIN_N-1:0] s1_ff;
   logic [PIN_N-1:0] s2_ff;
   logic [PIN_N-1:0] s3_ff;
   logic [PIN_N-1:0] filt_ff;
   logic [PIN_N-1:0] fall_ff;
   logic [PIN_N-1:0] agree;

   // ********************************************************
   // Synchroniser chain
   // ********************************************************
   // Pins idle high, so reset to one avoids a false fall
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_ff <= '1;
         s2_ff <= '1;
         s3_ff <= '1;
      end
      else
      begin
         s1_ff <= pin.raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   assign agree = ~(s2_ff ^ s3_ff);

   // ********************************************************
   // Filtered level and falling edge
   // ********************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         filt_ff <= '1;
         fall_ff <= '0;
      end
      else
      begin
         filt_ff <= (agree & s2_ff) | (~agree & filt_ff);
         fall_ff <= agree & ~s2_ff & filt_ff;
      end
   end

   assign pin.filt = filt_ff;
   assign pin.fall = fall_ff;

endmodule // dtc_pin_sync

`default_nettype wire

// *** design/dtc_top.sv ***
// Dual timer/counter with external interrupt flags, Wishbone slave
`default_nettype none

// How it works
// R1: Timer 1 overflow sets its flag; vectoring to its routine clears it.
// R2: Timer 1 run bit starts timer 1 when set, stops it when clear; while timer 0 is split, timer 1 also runs with the bit clear.
// R3: Timer 0 overflow sets its flag; vectoring or software write clears it.
// R4: Timer 0 run bit starts timer 0 when set, stops it when clear.
// R5: Interrupt 1 pin activity sets its pending flag; edge mode clears on service.
// R6: Interrupt 1 type bit: clear means low level, set means falling edge.
// R7: Interrupt 0 pin activity sets its pending flag; edge mode clears on service.
// R8: Interrupt 0 type bit: clear means low level, set means falling edge.
// R9: Timer 1 gating makes it run only while interrupt 1 pin is high.
// R10: Timer 1 source bit picks peripheral ticks or count pin falling edges.
// R11: Timer 1 modes: 13-bit, 16-bit, 8-bit reload, or halted holding count.
// R12: Timer 1 reload mode copies high byte into low byte on overflow.
// R13: Timer 0 gating makes it run only while interrupt 0 pin is high.
// R14: Timer 0 source bit picks peripheral ticks or count pin falling edges.
// R15: Timer 0 modes 13/16/reload, or split using timer 1 run and flag.
// R16: Timer 0 reload mode copies high byte into low byte on overflow.
// R17: Each count is a high and low byte register, reset to zero.
// R18: Count pin sampled once per tick; high then low counts one.
// R19: In timer operation the count steps once per peripheral tick.
// R20: Overflow is all ones rolling to zero; it sets the overflow flag.
// R21: 13-bit mode uses low five bits as a modulo-32 prescaler.
// R22: Software stops a timer before changing its mode or source.
module dtc_top
   import dtc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   output logic [31:0] dat_o,
   input wire logic ext_irq0_pin_n_i,
   input wire logic ext_irq1_pin_n_i,
   input wire logic timer0_count_pin_i,
   input wire logic timer1_count_pin_i,
   input wire logic tmr0_vec_i,
   input wire logic tmr1_vec_i,
   input wire logic ext0_vec_i,
   input wire logic ext1_vec_i,
   output logic tmr0_irq_o,
   output logic tmr1_irq_o,
   output logic ext0_irq_o,
   output logic ext1_irq_o
);

   // ********************************************************
   // Helpers
   // ********************************************************
   // Returns {overflow, high, low} after one count step
   function automatic logic [16:0] dtc_step(input dtc_mode_t m,
                                            input logic [7:0] th,
                                            input logic [7:0] tl);
      logic [16:0] r;
      r = {1'b0, th, tl};
      case (m)
         MODE_13BIT:
         begin
            // Upper three low bits are left alone
            r[4:0] = tl[4:0] + 5'h01;
            if (tl[4:0] == 5'h1f)
               r[16:8] = {1'b0, th} + 9'h001;
         end
         MODE_16BIT:
            r = {1'b0, th, tl} + 17'h00001;
         MODE_RELOAD:
         begin
            if (tl == 8'hff)
               r = {1'b1, th, th};
            else
               r[7:0] = tl + 8'h01;
         end
         default:
            r = {1'b0, th, tl};
      endcase
      return r;
   endfunction

   function automatic logic [8:0] dtc_inc8(input logic [7:0] v);
      return {1'b0, v} + 9'h001;
   endfunction

   // Hardware set beats every clear in the same cycle
   function automatic logic dtc_flag(input logic set, input logic clr,
                                     input logic wr, input logic wv,
                                     input logic cur);
      if (set)
         return 1'b1;
      else if (clr)
         return 1'b0;
      else if (wr)
         return wv;
      return cur;
   endfunction

   // ********************************************************
   // Declarations
   // ********************************************************
   dtc_pin_if pins();

   logic ack_ff;
   logic [7:0] rdat_ff;
   logic [7:0] rd_byte;
   logic [IDX_W-1:0] idx;
   logic wr_en;
   logic [7:0] wdat;
   logic [7:0] mode_ff;
   logic tr0_ff, tr1_ff, it0_ff, it1_ff;
   logic tf0_ff, tf1_ff, ie0_ff, ie1_ff;
   logic [7:0] tl0_ff, th0_ff, tl1_ff, th1_ff;
   logic [7:0] nxt_tl0, nxt_th0, nxt_tl1, nxt_th1;
   logic [2:0] div_ff;
   logic tick_ff;
   logic [1:0] samp_ff;
   logic cnt0_ev, cnt1_ev, ev0, ev1;
   logic run0, run1, inc0, inc1, inc_th0;
   logic t0_ovf, t1_ovf, th0_ovf;
   logic t0_split;
   dtc_mode_t mode0, mode1;

   // ********************************************************
   // Pin synchroniser
   // ********************************************************
   assign pins.raw[PIN_IRQ0] = ext_irq0_pin_n_i;
   assign pins.raw[PIN_IRQ1] = ext_irq1_pin_n_i;
   assign pins.raw[PIN_CNT0] = timer0_count_pin_i;
   assign pins.raw[PIN_CNT1] = timer1_count_pin_i;

   dtc_pin_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin(pins.sync_end)
   );

   // ********************************************************
   // Wishbone slave
   // ********************************************************
   // Ack one cycle after the request; write lands on the ack edge
   assign idx = adr_i[ADR_W-1:2];
   assign wdat = dat_i[7:0];
   assign wr_en = cyc_i && stb_i && we_i && ack_ff && sel_i[0];

   always_comb
   begin
      case (idx)
         IDX_CTRL: rd_byte = {tf1_ff, tr1_ff, tf0_ff, tr0_ff,
                              ie1_ff, it1_ff, ie0_ff, it0_ff};
         IDX_MODE: rd_byte = mode_ff;
         IDX_TL0: rd_byte = tl0_ff;
         IDX_TL1: rd_byte = tl1_ff;
         IDX_TH0: rd_byte = th0_ff;
         IDX_TH1: rd_byte = th1_ff;
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
         rdat_ff <= 8'h00;
      end
      else
      begin
         ack_ff <= cyc_i && stb_i && !ack_ff;
         if (cyc_i && stb_i && !ack_ff)
            rdat_ff <= rd_byte;
      end
   end

   assign ack_o = ack_ff;
   assign dat_o = {24'h000000, rdat_ff};

   // ********************************************************
   // Control and mode registers
   // ********************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tr0_ff <= 1'b0;
         tr1_ff <= 1'b0;
         it0_ff <= 1'b0;
         it1_ff <= 1'b0;
         mode_ff <= RST_BYTE;
      end
      else
      begin
         if (wr_en && idx == IDX_CTRL)
         begin
            tr1_ff <= wdat[CTL_TR1]; // [R2]
            tr0_ff <= wdat[CTL_TR0]; // [R4]
            it1_ff <= wdat[CTL_IT1]; // [R6]
            it0_ff <= wdat[CTL_IT0]; // [R8]
         end
         if (wr_en && idx == IDX_MODE)
            mode_ff <= wdat;
      end
   end

   assign mode0 = dtc_mode_t'(mode_ff[MOD_M0_HI:MOD_M0_LO]);
   assign mode1 = dtc_mode_t'(mode_ff[MOD_M1_HI:MOD_M1_LO]);
   assign t0_split = (mode0 == MODE_SPLIT);

   // ********************************************************
   // Peripheral tick and count pin sampling
   // ********************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_ff <= 3'h0;
         tick_ff <= 1'b0;
      end
      else
      begin
         tick_ff <= (div_ff == PERIPH_CYC - 3'h1); // [R19]
         if (div_ff == PERIPH_CYC - 3'h1)
            div_ff <= 3'h0;
         else
            div_ff <= div_ff + 3'h1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         samp_ff <= 2'h3;
      else if (tick_ff)
         samp_ff <= {pins.filt[PIN_CNT1], pins.filt[PIN_CNT0]}; // [R18]
   end

   // High on the last tick, low on this one
   assign cnt0_ev = tick_ff && samp_ff[0] && !pins.filt[PIN_CNT0]; // [R18]
   assign cnt1_ev = tick_ff && samp_ff[1] && !pins.filt[PIN_CNT1];

   // ********************************************************
   // Run gating and count sources
   // ********************************************************
   assign ev0 = mode_ff[MOD_CT0] ? cnt0_ev : tick_ff; // [R14]
   assign ev1 = mode_ff[MOD_CT1] ? cnt1_ev : tick_ff; // [R10]
   assign run0 = tr0_ff &&
                 (!mode_ff[MOD_TIMER0_PIN_GATING] || pins.filt[PIN_IRQ0]); // [R4] [R13]
   // While timer 0 is split, timer 1 is switched by its halt mode
   assign run1 = (t0_split || tr1_ff) &&
                 (!mode_ff[MOD_TIMER1_PIN_GATING] || pins.filt[PIN_IRQ1]); // [R2] [R9]
   assign inc0 = run0 && ev0;
   assign inc1 = run1 && ev1;
   assign inc_th0 = t0_split && tr1_ff && tick_ff; // [R15]

   // ********************************************************
   // Timer 0 count
   // ********************************************************
   always_comb
   begin
      nxt_tl0 = tl0_ff;
      nxt_th0 = th0_ff;
      t0_ovf = 1'b0;
      th0_ovf = 1'b0;
      if (t0_split)
      begin
         if (inc0)
            {t0_ovf, nxt_tl0} = dtc_inc8(tl0_ff); // [R15]
         if (inc_th0)
            {th0_ovf, nxt_th0} = dtc_inc8(th0_ff); // [R15]
      end
      else if (inc0)
         {t0_ovf, nxt_th0, nxt_tl0} =
            dtc_step(mode0, th0_ff, tl0_ff); // [R16] [R21] [R20]
      // A software write wins over a count in the same cycle
      if (wr_en && idx == IDX_TL0)
         nxt_tl0 = wdat;
      if (wr_en && idx == IDX_TH0)
         nxt_th0 = wdat;
   end

   // ********************************************************
   // Timer 1 count
   // ********************************************************
   always_comb
   begin
      nxt_tl1 = tl1_ff;
      nxt_th1 = th1_ff;
      t1_ovf = 1'b0;
      if (inc1)
         {t1_ovf, nxt_th1, nxt_tl1} =
            dtc_step(mode1, th1_ff, tl1_ff); // [R11] [R12] [R21]
      if (wr_en && idx == IDX_TL1)
         nxt_tl1 = wdat;
      if (wr_en && idx == IDX_TH1)
         nxt_th1 = wdat;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tl0_ff <= RST_BYTE; // [R17]
         th0_ff <= RST_BYTE;
         tl1_ff <= RST_BYTE;
         th1_ff <= RST_BYTE;
      end
      else
      begin
         tl0_ff <= nxt_tl0;
         th0_ff <= nxt_th0;
         tl1_ff <= nxt_tl1;
         th1_ff <= nxt_th1;
      end
   end

   // ********************************************************
   // Overflow and external interrupt flags
   // ********************************************************
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         tf0_ff <= 1'b0;
         tf1_ff <= 1'b0;
         ie0_ff <= 1'b0;
         ie1_ff <= 1'b0;
      end
      else
      begin
         tf0_ff <= dtc_flag(t0_ovf, tmr0_vec_i,
                            wr_en && idx == IDX_CTRL,
                            wdat[CTL_TF0], tf0_ff); // [R3] [R20]
         // Split mode hands timer 1's flag to the timer 0 high byte
         tf1_ff <= dtc_flag(t0_split ? th0_ovf : t1_ovf, tmr1_vec_i,
                            wr_en && idx == IDX_CTRL,
                            wdat[CTL_TF1], tf1_ff); // [R1] [R15]
         // Level mode mirrors the pin; only edge mode is cleared
         ie0_ff <= dtc_flag(it0_ff ? pins.fall[PIN_IRQ0]
                                   : !pins.filt[PIN_IRQ0],
                            it0_ff ? ext0_vec_i : pins.filt[PIN_IRQ0],
                            it0_ff && wr_en && idx == IDX_CTRL,
                            wdat[CTL_IE0], ie0_ff); // [R7] [R8]
         ie1_ff <= dtc_flag(it1_ff ? pins.fall[PIN_IRQ1]
                                   : !pins.filt[PIN_IRQ1],
                            it1_ff ? ext1_vec_i : pins.filt[PIN_IRQ1],
                            it1_ff && wr_en && idx == IDX_CTRL,
                            wdat[CTL_IE1], ie1_ff); // [R5] [R6]
      end
   end

   assign tmr0_irq_o = tf0_ff;
   assign tmr1_irq_o = tf1_ff;
   assign ext0_irq_o = ie0_ff;
   assign ext1_irq_o = ie1_ff;

   // ********************************************************
   // Checks
   // ********************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_tf1_vector: assert property ( // [R1]
      tmr1_vec_i && !(t0_split ? th0_ovf : t1_ovf) |=> !tf1_ff)
      else $error("timer 1 flag not cleared by vectoring");

   chk_tf0_set: assert property ( // [R3]
      t0_ovf |=> tf0_ff && tmr0_irq_o)
      else $error("timer 0 overflow did not set its flag");

   chk_t0_stopped: assert property ( // [R4]
      !tr0_ff && !wr_en |=> $stable(tl0_ff))
      else $error("timer 0 low byte moved while stopped");

   chk_ie1_edge: assert property ( // [R5]
      it1_ff && pins.fall[PIN_IRQ1] |=> ie1_ff)
      else $error("falling edge on interrupt 1 pin not flagged");

   chk_ie0_level: assert property ( // [R8]
      !it0_ff && !pins.filt[PIN_IRQ0] ##1 !it0_ff |-> ie0_ff)
      else $error("low level on interrupt 0 pin not flagged");

   chk_timer0_pin_gating_hold: assert property ( // [R13]
      mode_ff[MOD_TIMER0_PIN_GATING] && !pins.filt[PIN_IRQ0] && !wr_en && !t0_split
      |=> $stable({th0_ff, tl0_ff}))
      else $error("gated timer 0 counted with pin low");

   chk_reload1: assert property ( // [R12]
      mode1 == MODE_RELOAD && inc1 && tl1_ff == 8'hff && !wr_en
      |=> tl1_ff == $past(th1_ff) && (tf1_ff || t0_split))
      else $error("timer 1 reload did not copy high byte");

   chk_halt1: assert property ( // [R11]
      mode1 == MODE_SPLIT && !wr_en |=> $stable({th1_ff, tl1_ff}))
      else $error("halted timer 1 changed its count");

   chk_tick_rate: assert property ( // [R19]
      tick_ff |=> !tick_ff [*5] ##1 tick_ff)
      else $error("peripheral tick spacing is wrong");

   chk_cnt_edge: assert property ( // [R18]
      cnt0_ev |-> $past(pins.filt[PIN_CNT0], 6) && !pins.filt[PIN_CNT0])
      else $error("count pin event without high then low samples");

endmodule // dtc_top

`default_nettype wire

// *** verif/dtc_pin_model.sv ***
// Behavioural model of the interrupt and count pins
`default_nettype none

module dtc_pin_model
   import dtc_pkg::*;
#(
   parameter int HOLD = 15
)
(
   input wire logic clk_i,
   output logic [PIN_N-1:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle high, as the pull-ups leave the pins
   initial pin_o = 4'hf;

   task automatic set_pin(input int k, input logic lvl);
      @(posedge clk_i);
      pin_o[k] <= lvl;
   endtask

   // Each level held over two ticks so no sample is missed
   task automatic falls(input int k, input int n);
      repeat (n)
      begin
         set_pin(k, 1'b0);
         repeat (HOLD) @(posedge clk_i);
         set_pin(k, 1'b1);
         repeat (HOLD) @(posedge clk_i);
      end
   endtask

endmodule // dtc_pin_model

`default_nettype wire

// *** verif/tb_dtc_top.sv ***
// Self-checking bench for the dual timer/counter block
`default_nettype none

module tb_dtc_top
   import dtc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [ADR_W-1:0] adr = '0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [3:0] sel = 4'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic ack;
   logic [3:0] vec = 4'h0;
   logic [3:0] irq;
   logic [PIN_N-1:0] pin;
   int n_mismatch = 0;
   int n_compared = 0;

   always #5 clk_i = ~clk_i;

   dtc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
      .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .ack_o(ack),
      .dat_o(rdat), .ext_irq0_pin_n_i(pin[PIN_IRQ0]),
      .ext_irq1_pin_n_i(pin[PIN_IRQ1]), .timer0_count_pin_i(pin[PIN_CNT0]),
      .timer1_count_pin_i(pin[PIN_CNT1]), .tmr0_vec_i(vec[0]),
      .tmr1_vec_i(vec[1]), .ext0_vec_i(vec[2]), .ext1_vec_i(vec[3]),
      .tmr0_irq_o(irq[0]), .tmr1_irq_o(irq[1]), .ext0_irq_o(irq[2]),
      .ext1_irq_o(irq[3]));

   dtc_pin_model pm_u (.clk_i(clk_i), .pin_o(pin));

   // ********************************************************
   // Bus and compare helpers
   // ********************************************************
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'h1;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      chk("bus ack", 8'h1, {7'h0, ack});
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, idx, d, q);
   endtask

   task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      wb(1'b0, idx, 8'h00, q);
      chk($sformatf("reg %h", idx), exp, q);
   endtask

   task automatic wait_irq(input int k);
      int n;
      n = 0;
      while (irq[k] !== 1'b1 && n < 3000)
      begin
         @(posedge clk_i);
         n++;
      end
      chk($sformatf("irq %0d up", k), 8'h1, {7'h0, irq[k]});
   endtask

   // Vector pulse, then the flag must be gone
   task automatic serve(input int k);
      @(posedge clk_i);
      vec[k] <= 1'b1;
      @(posedge clk_i);
      vec[k] <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk($sformatf("irq %0d served", k), 8'h0, {7'h0, irq[k]});
   endtask

   // ********************************************************
   // Scenarios
   // ********************************************************
   task automatic t_regs();
      logic [7:0] ix [6] = '{IDX_CTRL, IDX_MODE, IDX_TL0, IDX_TL1,
                             IDX_TH0, IDX_TH1};
      foreach (ix[i]) rc(ix[i], 8'h00);
      for (int i = 1; i < 6; i++) wr(ix[i], 8'h31 + 8'(i));
      for (int i = 1; i < 6; i++) rc(ix[i], 8'h31 + 8'(i));
      wr(8'h90, 8'h5a);
      rc(8'h90, 8'h00);
      wr(IDX_MODE, 8'h00);
      $display("done regs");
   endtask

   // Start from all ones, stop right after the wrap
   task automatic t_wrap(input int k, input logic [1:0] m);
      logic [7:0] tl;
      logic [7:0] th;
      logic [7:0] md;
      logic [7:0] el;
      logic [7:0] eh;
      tl = k ? IDX_TL1 : IDX_TL0;
      th = k ? IDX_TH1 : IDX_TH0;
      md = {6'h0, m} << (4 * k);
      el = (m == 2'd0) ? 8'he0 : (m == 2'd1) ? 8'h00 : 8'hff;
      eh = (m == 2'd2) ? 8'hff : 8'h00;
      wr(IDX_CTRL, 8'h00);
      wr(IDX_MODE, md);
      wr(th, 8'hff);
      wr(tl, 8'hff);
      wr(IDX_CTRL, k ? 8'h40 : 8'h10);
      wait_irq(k);
      wr(IDX_CTRL, k ? 8'h80 : 8'h20);
      rc(IDX_CTRL, k ? 8'h80 : 8'h20);
      rc(tl, el);
      rc(th, eh);
      serve(k);
      repeat (20) @(posedge clk_i);
      rc(tl, el);
      $display("done wrap %0d mode %0d", k, m);
   endtask

   task automatic t_halt_split();
      wr(IDX_CTRL, 8'h00);
      wr(IDX_MODE, 8'h30);
      wr(IDX_TL1, 8'h12);
      wr(IDX_CTRL, 8'h40);
      repeat (60) @(posedge clk_i);
      rc(IDX_TL1, 8'h12);
      wr(IDX_CTRL, 8'h00);
      wr(IDX_MODE, 8'h03);
      wr(IDX_TL0, 8'h00);
      wr(IDX_TH0, 8'hff);
      wr(IDX_CTRL, 8'h40);
      wait_irq(1);
      wr(IDX_CTRL, 8'h80);
      rc(IDX_TH0, 8'h00);
      rc(IDX_TL0, 8'h00);
      serve(1);
      $display("done halt split");
   endtask

   task automatic t_count();
      wr(IDX_CTRL, 8'h00);
      wr(IDX_MODE, 8'h55);
      foreach (pin[i]) if (i < 4) wr(IDX_TL0 + 8'(i), 8'h00);
      wr(IDX_CTRL, 8'h50);
      pm_u.falls(PIN_CNT0, 3);
      pm_u.falls(PIN_CNT1, 2);
      repeat (20) @(posedge clk_i);
      wr(IDX_CTRL, 8'h00);
      rc(IDX_TL0, 8'h03);
      rc(IDX_TL1, 8'h02);
      $display("done count");
   endtask

   task automatic t_gate_level();
      wr(IDX_MODE, 8'h99);
      foreach (pin[i]) if (i < 4) wr(IDX_TL0 + 8'(i), 8'hff);
      pm_u.set_pin(PIN_IRQ0, 1'b0);
      pm_u.set_pin(PIN_IRQ1, 1'b0);
      wr(IDX_CTRL, 8'h50);
      repeat (60) @(posedge clk_i);
      chk("gated", 8'h0, {6'h0, irq[1:0]});
      chk("level", 8'h3, {6'h0, irq[3:2]});
      pm_u.set_pin(PIN_IRQ0, 1'b1);
      pm_u.set_pin(PIN_IRQ1, 1'b1);
      wait_irq(0);
      wait_irq(1);
      repeat (8) @(posedge clk_i);
      chk("level off", 8'h0, {6'h0, irq[3:2]});
      wr(IDX_CTRL, 8'h00);
      $display("done gate level");
   endtask

   task automatic t_edge();
      wr(IDX_CTRL, 8'h05);
      for (int k = 0; k < 2; k++)
      begin
         pm_u.set_pin(k ? PIN_IRQ1 : PIN_IRQ0, 1'b0);
         repeat (10) @(posedge clk_i);
         pm_u.set_pin(k ? PIN_IRQ1 : PIN_IRQ0, 1'b1);
         repeat (10) @(posedge clk_i);
         chk("edge held", 8'h1, {7'h0, irq[2 + k]});
         rc(IDX_CTRL, k ? 8'h0d : 8'h07);
         serve(2 + k);
      end
      $display("done edge");
   endtask

   // ********************************************************
   // Sequence and verdict
   // ********************************************************
   task automatic wrap_up();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      for (int k = 0; k < 2; k++)
         for (int m = 0; m < 3; m++) t_wrap(k, 2'(m));
      t_halt_split();
      t_count();
      t_gate_level();
      t_edge();
      wrap_up();
   end

   // Whole run is about a thousand cycles
   initial
   begin
      #200000;
      n_mismatch++;
      wrap_up();
   end

endmodule // tb_dtc_top

`default_nettype wire
